// *** hdl/prm_defs.svh ***
// Purpose: constants of the tone-pin routing and modulation register bank
// Assumes: register offsets are word addresses on the command port
// Notes:   included by the package and the testbench
//
// Summary of operation
// R01 - access mode picks write, set, clear, toggle
// R02 - code 000 routes command processor to pin
// R03 - code 001 forces the pin low
// R04 - code 010 routes front-panel input n
// R05 - per-pin invert bit inverts selected source
// R06 - codes at bits 11:3, inverts at 2:0
// R07 - reset bit requests synthesizer and processor reset
// R08 - controller waits 100 ms after reset request
// R09 - reset bit self-clears when reset completes
// R10 - commands during reset are flushed silently
// R11 - queued reset acts only when processor reaches it
// R12 - writes hit shadows; commit bit copies all
// R13 - scale for input 0, signed 18 bits
// R14 - scale for input 1, same format
// R15 - global offset, signed 24 bits
// R16 - polar offset keeps upper 16 of 24
// R17 - per-input offsets, signed 18 bits
// R18 - format 00 amplitude 14 bits, 01 phase
// R19 - format field drives synthesizer format lines
// R20 - each channel owns its own register set
// R21 - format 10 frequency, 11 polar 8+8
// R22 - sum scaled differences, drop 12 bits, add offset
// R23 - result saturates to unsigned 16 bits
// R24 - access modes touch only code and invert bits
`ifndef PRM_DEFS_SVH
`define PRM_DEFS_SVH

// ************************************************
// register offsets
// ************************************************
`define PRM_ADDR_W       9
`define PRM_ADDR_ROUTE   9'h088
`define PRM_ADDR_RESET   9'h08a
`define PRM_ADDR_SCALE0  9'h100
`define PRM_ADDR_SCALE1  9'h101
`define PRM_ADDR_GOFS    9'h102
`define PRM_ADDR_OFS0    9'h103
`define PRM_ADDR_OFS1    9'h104
`define PRM_ADDR_FMT     9'h105
`define PRM_ADDR_POLAR   9'h106

// ************************************************
// field layout
// ************************************************
`define PRM_WACT_MSB     31
`define PRM_WACT_LSB     30
`define PRM_COMMIT_BIT   29
`define PRM_RST_BIT      0
`define PRM_ROUTE_W      12
`define PRM_OP_LSB       3
`define PRM_POLAR_LSB    8
`define PRM_SHIFT        12

// ************************************************
// codes and reset values
// ************************************************
`define PRM_WACT_WRITE   2'h0
`define PRM_WACT_SET     2'h1
`define PRM_WACT_CLEAR   2'h2
`define PRM_WACT_TOGGLE  2'h3
`define PRM_SRC_CP       3'h0
`define PRM_SRC_LOW      3'h1
`define PRM_SRC_PANEL    3'h2
`define PRM_FMT_AM       2'h0
`define PRM_FMT_PM       2'h1
`define PRM_FMT_FM       2'h2
`define PRM_FMT_POLAR    2'h3
`define PRM_AM_MASK      16'hfffc
`define PRM_ROUTE_RST    12'h000
`define PRM_RESET_WAIT_MS 100

`endif

// *** hdl/prm_pkg.sv ***
// Purpose: types of the tone-pin routing and modulation register bank
// Assumes: constants come from prm_defs.svh
// Notes:   one coefficient set is kept twice, shadow and effective
`include "prm_defs.svh"

package prm_pkg;

	typedef struct packed {
		logic [17:0] scale0;
		logic [17:0] scale1;
		logic [23:0] gofs;
		logic [17:0] ofs0;
		logic [17:0] ofs1;
		logic [1:0]  fmt;
		logic [15:0] polar;
	} prm_coef_t;

	typedef struct packed {
		logic [`PRM_ROUTE_W-1:0] route;
		logic                    rstReq;
		prm_coef_t               sh;
		prm_coef_t               eff;
		logic [2:0]              panelMeta;
		logic [2:0]              panelSync;
		logic [2:0]              pins;
		logic [15:0]             data;
		logic [1:0]              fmt;
	} prm_state_t;

endpackage : prm_pkg

// *** hdl/prm_regs.sv ***
// Purpose: per-channel routing, synthesizer reset and modulation registers
// Assumes: one instance per output channel, all on ref_clk
// Notes:   written by the channel's command processor; no read-back bus
`timescale 1ns/10ps

module prm_regs
	import prm_pkg::*;
(
	// clock and reset
	input  wire logic                   ref_clk,
	input  wire logic                   nrst,
	// command processor register writes
	input  wire logic                   regWrEn,
	input  wire logic [`PRM_ADDR_W-1:0] regAddr,
	input  wire logic [31:0]            regWrData,
	// command processor, slot controller and front panel
	input  wire logic [2:0]             cpToneSel,
	input  wire logic                   cpResetDone,
	input  wire logic [2:0]             panelIn,
	// sampled analog inputs
	input  wire logic [15:0]            adcSample0,
	input  wire logic [15:0]            adcSample1,
	// synthesizer side
	output logic      [2:0]             toneSelPin,
	output logic      [15:0]            modData,
	output logic      [1:0]             modFormat,
	// status
	output logic                        synthResetReq,
	output logic                        cpQueueFlush,
	output logic      [`PRM_ROUTE_W-1:0] routeState
);

	// ************************************************
	// helper functions
	// ************************************************

	function automatic logic pin_drive(
		input logic [2:0] code,
		input logic       inv,
		input logic       cpSrc,
		input logic       panelSrc
	);
		logic src;
		case (code)
			// R02 command processor path
			`PRM_SRC_CP: src = cpSrc;
			// R03 forced low
			`PRM_SRC_LOW: src = 1'b0;
			// R04 front-panel path
			`PRM_SRC_PANEL: src = panelSrc;
			// unlisted codes fall back to the processor path
			default: src = cpSrc;
		endcase
		// R05 per-pin inversion
		return src ^ inv;
	endfunction : pin_drive

	// R22 one scaled term, kept at full product width
	function automatic logic signed [35:0] mod_term(
		input logic [15:0] sample,
		input logic [17:0] ofs,
		input logic [17:0] scl
	);
		logic signed [17:0] diff;
		diff = $signed({sample[15], sample[15], sample}) - $signed(ofs);
		return diff * $signed(scl);
	endfunction : mod_term

	// R23 clip to unsigned 16 bits
	function automatic logic [15:0] sat16(input logic signed [25:0] x);
		if (x < 26'sh0) begin
			return 16'h0000;
		end else if (x > 26'sh00ffff) begin
			return 16'hffff;
		end
		return x[15:0];
	endfunction : sat16

	// ************************************************
	// state
	// ************************************************

	prm_state_t st;
	prm_state_t next_st;

	logic                    wrRoute;
	logic                    wrReset;
	logic                    wrCoef;
	logic                    commit;
	logic [1:0]              wact;
	logic [`PRM_ROUTE_W-1:0] wdat;
	logic signed [35:0]      term0;
	logic signed [35:0]      term1;
	logic signed [36:0]      prodSum;
	logic signed [25:0]      sumLin;
	logic signed [25:0]      sumPhase;
	logic signed [25:0]      sumAmp;
	logic [15:0]             linWord;
	logic [15:0]             phaseWord;
	logic [15:0]             ampWord;

	// ************************************************
	// address decode
	// ************************************************

	// R11 a queued write only arrives once the processor executes it
	assign wrRoute = regWrEn && (regAddr == `PRM_ADDR_ROUTE);
	assign wrReset = regWrEn && (regAddr == `PRM_ADDR_RESET);
	assign wrCoef  = regWrEn && (regAddr >= `PRM_ADDR_SCALE0)
	                         && (regAddr <= `PRM_ADDR_POLAR);
	assign commit  = wrCoef && regWrData[`PRM_COMMIT_BIT];
	assign wact    = regWrData[`PRM_WACT_MSB:`PRM_WACT_LSB];
	assign wdat    = regWrData[`PRM_ROUTE_W-1:0];

	// ************************************************
	// modulation math on effective coefficients
	// ************************************************

	always_comb begin
		term0     = mod_term(adcSample0, st.eff.ofs0, st.eff.scale0);
		term1     = mod_term(adcSample1, st.eff.ofs1, st.eff.scale1);
		// R22 whole sum first, then low 12 bits dropped, then global offset
		// dropping bits per term would lose the carry between the two terms
		prodSum   = 37'(term0) + 37'(term1);
		sumLin    = 26'($signed(prodSum[36:`PRM_SHIFT]))
		          + 26'($signed(st.eff.gofs));
		// R16 polar offset sits in bits 23:8, low byte ignored
		sumPhase  = 26'($signed(term0[35:`PRM_SHIFT]))
		          + 26'($signed({st.eff.polar, 8'h00}));
		sumAmp    = 26'($signed(term1[35:`PRM_SHIFT]))
		          + 26'($signed(st.eff.gofs));
		linWord   = sat16(sumLin);
		phaseWord = sat16(sumPhase);
		ampWord   = sat16(sumAmp);
	end

	// ************************************************
	// next state
	// ************************************************

	always_comb begin
		next_st = st;

		// R24 access modes act on bits 11:0 only
		if (wrRoute) begin
			// R01 write action select
			case (wact)
				`PRM_WACT_WRITE: next_st.route = wdat;
				`PRM_WACT_SET: next_st.route = st.route | wdat;
				`PRM_WACT_CLEAR: next_st.route = st.route & ~wdat;
				`PRM_WACT_TOGGLE: next_st.route = st.route ^ wdat;
				default: next_st.route = st.route;
			endcase
		end

		// R09 cleared when the processor reset completes
		if (cpResetDone) begin
			next_st.rstReq = 1'b0;
		end
		// R07 a new request wins over a same-cycle completion
		if (wrReset && regWrData[`PRM_RST_BIT]) begin
			next_st.rstReq = 1'b1;
		end

		// R12 every coefficient write lands in the shadow set
		if (wrCoef) begin
			case (regAddr)
				// R13 scale for input 0
				`PRM_ADDR_SCALE0: next_st.sh.scale0 = regWrData[17:0];
				// R14 scale for input 1
				`PRM_ADDR_SCALE1: next_st.sh.scale1 = regWrData[17:0];
				// R15 global offset
				`PRM_ADDR_GOFS: next_st.sh.gofs = regWrData[23:0];
				// R17 per-input offsets
				`PRM_ADDR_OFS0: next_st.sh.ofs0 = regWrData[17:0];
				`PRM_ADDR_OFS1: next_st.sh.ofs1 = regWrData[17:0];
				`PRM_ADDR_FMT: next_st.sh.fmt = regWrData[1:0];
				// R16 low 8 bits dropped
				`PRM_ADDR_POLAR: next_st.sh.polar = regWrData[23:`PRM_POLAR_LSB];
				default: next_st.sh = st.sh;
			endcase
		end
		// R12 commit includes the value written alongside it
		if (commit) begin
			next_st.eff = next_st.sh;
		end

		// panel pins cross in through two flops
		next_st.panelMeta = panelIn;
		next_st.panelSync = st.panelMeta;

		for (int n = 0; n < 3; n++) begin
			// R06 codes at 3n+3, invert at n
			next_st.pins[n] = pin_drive(st.route[`PRM_OP_LSB + 3*n +: 3],
			                            st.route[n], cpToneSel[n],
			                            st.panelSync[n]);
		end

		// R19 format follows the data onto the parallel port
		next_st.fmt = st.eff.fmt;
		case (st.eff.fmt)
			// R18 amplitude keeps upper 14 bits
			`PRM_FMT_AM: next_st.data = linWord & `PRM_AM_MASK;
			// R18 phase uses all 16 bits
			`PRM_FMT_PM: next_st.data = linWord;
			// R21 frequency uses all 16 bits
			`PRM_FMT_FM: next_st.data = linWord;
			// R21 polar: phase byte high, amplitude byte low
			`PRM_FMT_POLAR: next_st.data = {phaseWord[15:8], ampWord[15:8]};
			default: next_st.data = linWord;
		endcase
	end

	// ************************************************
	// registers
	// ************************************************

	// R20 one instance of all this per channel
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			st       <= '0;
			// R02 all pins start on the processor path
			st.route <= `PRM_ROUTE_RST;
		end else begin
			st <= next_st;
		end
	end

	assign toneSelPin    = st.pins;
	assign modData       = st.data;
	assign modFormat     = st.fmt;
	assign synthResetReq = st.rstReq;
	// R10 processor queue held empty while reset runs
	assign cpQueueFlush  = st.rstReq;
	assign routeState    = st.route;

	// ************************************************
	// assertions
	// ************************************************

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	sequence s_rstWrite;
		wrReset && regWrData[`PRM_RST_BIT];
	endsequence

	sequence s_rstPending;
		st.rstReq && !cpResetDone && !wrReset;
	endsequence

	a_route_set: assert property ( // R01
		wrRoute && wact == `PRM_WACT_SET |=>
		st.route == ($past(st.route) | $past(wdat)))
		else $error("set access did not or bits in");

	a_route_write: assert property ( // R01
		wrRoute && wact == `PRM_WACT_WRITE |=> st.route == $past(wdat))
		else $error("plain write did not load route");

	a_route_toggle: assert property ( // R01
		wrRoute && wact == `PRM_WACT_TOGGLE |=>
		st.route == ($past(st.route) ^ $past(wdat)))
		else $error("toggle access did not flip bits");

	a_route_clear: assert property ( // R24
		wrRoute && wact == `PRM_WACT_CLEAR |=>
		st.route == ($past(st.route) & ~$past(wdat)))
		else $error("clear access did not clear bits");

	a_pin_low: assert property ( // R03
		st.route[5:3] == `PRM_SRC_LOW |=> toneSelPin[0] == $past(st.route[0]))
		else $error("forced pin not at inverted low");

	a_pin_panel: assert property ( // R04
		st.route[5:3] == `PRM_SRC_PANEL |=>
		toneSelPin[0] == ($past(st.panelSync[0]) ^ $past(st.route[0])))
		else $error("pin 0 does not follow panel input");

	a_pin_cp: assert property ( // R05
		st.route[8:6] == `PRM_SRC_CP |=>
		toneSelPin[1] == ($past(cpToneSel[1]) ^ $past(st.route[1])))
		else $error("pin 1 does not follow processor");

	a_reset_set: assert property ( // R07
		s_rstWrite |=> synthResetReq ##0 cpQueueFlush)
		else $error("reset request not raised");

	a_reset_hold: assert property ( // R10
		s_rstPending |=> synthResetReq)
		else $error("reset request dropped early");

	a_reset_clear: assert property ( // R09
		st.rstReq && cpResetDone && !wrReset |=> !synthResetReq)
		else $error("reset request did not self clear");

	a_shadow_commit: assert property ( // R12
		commit |=> st.eff == st.sh ##1 modFormat == $past(st.eff.fmt))
		else $error("commit did not copy shadows");

	a_polar_shadow: assert property ( // R16
		wrCoef && regAddr == `PRM_ADDR_POLAR |=>
		st.sh.polar == $past(regWrData[23:`PRM_POLAR_LSB]))
		else $error("polar offset not taken from upper bits");

	a_shadow_hold: assert property ( // R12
		!commit |=> $stable(st.eff))
		else $error("effective set moved without commit");

	a_am_mask: assert property ( // R18
		st.eff.fmt == `PRM_FMT_AM |=> modData[1:0] == 2'h0)
		else $error("amplitude mode used low bits");

endmodule : prm_regs

// *** verification/prm_synth_model.sv ***
// Purpose: far side of the bank, slot controller finishing a synthesizer reset
// Assumes: one ref_clk domain, request is a level
// Notes:   DONE_DELAY sets how promptly or slowly the reset completes
`timescale 1ns/10ps

module prm_synth_model #(
	parameter int DONE_DELAY = 20
) (
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic nrst,
	// request and answer
	input  wire logic synthResetReq,
	output logic      cpResetDone
);
	logic [15:0] waitCnt;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			waitCnt     <= 16'h0;
			cpResetDone <= 1'b0;
		end else begin
			cpResetDone <= synthResetReq && waitCnt == 16'(DONE_DELAY - 1);
			waitCnt     <= (synthResetReq && !cpResetDone) ? waitCnt + 16'h1 : 16'h0;
		end
	end
endmodule : prm_synth_model

// *** verification/tb_top.sv ***
// Purpose: self-checking bench of the routing and modulation register bank
// Assumes: expectations worked out here, checked by a negedge monitor
// Notes:   reset completion delay shortened to a few tens of cycles
`timescale 1ns/10ps
`include "prm_defs.svh"

module tb_top;
	logic                   ref_clk, nrst, regWrEn, cpResetDone, chk;
	logic [`PRM_ADDR_W-1:0] regAddr;
	logic [31:0]            regWrData;
	logic [2:0]             cpToneSel, panelIn, toneSelPin, src;
	logic [15:0]            adcSample0, adcSample1, modData, rs, a0, a1;
	logic [1:0]             modFormat;
	logic                   synthResetReq, cpQueueFlush;
	logic [11:0]            routeState;
	logic [34:0]            qm[$], qv[$];
	logic signed [17:0]     sc0, sc1, o0, o1;
	logic signed [23:0]     go, gv[4];
	logic [1:0]             fm;
	int                     fail_count, check_count;
	wire logic [34:0] obs = {routeState, toneSelPin, synthResetReq, cpQueueFlush, modFormat, modData};

	prm_regs i_prm_regs (.ref_clk(ref_clk), .nrst(nrst), .regWrEn(regWrEn), .regAddr(regAddr),
		.regWrData(regWrData), .cpToneSel(cpToneSel), .cpResetDone(cpResetDone),
		.panelIn(panelIn), .adcSample0(adcSample0), .adcSample1(adcSample1),
		.toneSelPin(toneSelPin), .modData(modData), .modFormat(modFormat),
		.synthResetReq(synthResetReq), .cpQueueFlush(cpQueueFlush), .routeState(routeState));
	prm_synth_model #(.DONE_DELAY(20)) i_prm_synth_model (.ref_clk(ref_clk), .nrst(nrst),
		.synthResetReq(synthResetReq), .cpResetDone(cpResetDone));

	function automatic logic [34:0] ob(logic [11:0] r, logic [2:0] t, logic q, logic [1:0] f,
		logic [15:0] d);
		ob = {r, t, q, q, f, d};
	endfunction : ob

	function automatic logic [15:0] lfsr(logic [15:0] s);
		lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr

	function automatic logic [15:0] clip(logic signed [47:0] s);
		clip = (s < 0) ? 16'h0 : (s > 65535) ? 16'hffff : s[15:0];
	endfunction : clip

	// signed math, drop 12 bits of the sum, add offset, clip to 16 bits
	function automatic logic [15:0] mexp(logic [15:0] x0, logic [15:0] x1);
		logic signed [17:0] d0, d1;
		logic signed [47:0] p0, p1;
		logic [15:0]        ph, am;
		d0   = {{2{x0[15]}}, x0} - o0;
		d1   = {{2{x1[15]}}, x1} - o1;
		p0   = d0 * sc0;
		p1   = d1 * sc1;
		ph   = clip((p0 >>> 12) + 48'sh123400);
		am   = clip((p1 >>> 12) + go);
		mexp = clip(((p0 + p1) >>> 12) + go);
		if (fm == 2'h0)
			mexp = mexp & 16'hfffc;
		if (fm == 2'h3)
			mexp = {ph[15:8], am[15:8]};
	endfunction : mexp

	task automatic wr(logic [`PRM_ADDR_W-1:0] a, logic [31:0] d);
		@(posedge ref_clk);
		regWrEn   <= 1'b1;
		regAddr   <= a;
		regWrData <= d;
		@(posedge ref_clk);
		regWrEn   <= 1'b0;
	endtask : wr

	task automatic note(logic [34:0] m, logic [34:0] v);
		qm.push_back(m);
		qv.push_back(v);
		@(posedge ref_clk);
		chk <= 1'b1;
		@(posedge ref_clk);
		chk <= 1'b0;
	endtask : note

	task automatic check(logic [34:0] seen, logic [34:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : report_and_stop

	// ************
	// monitor
	// ************
	always @(negedge ref_clk) begin
		if (chk) begin
			check(obs & qm[0], qv[0] & qm[0]);
			void'(qm.pop_front());
			void'(qv.pop_front());
		end
	end

	initial ref_clk = 1'b0;
	always #2 ref_clk = ~ref_clk;

	initial begin
		#80000;
		fail_count++;
		report_and_stop();
	end

	// ************
	// scenarios
	// ************
	initial begin
		{nrst, regWrEn, chk, regAddr, regWrData, cpToneSel, panelIn} = '0;
		{adcSample0, adcSample1, sc0, sc1, o0, o1, go, fm} = '0;
		rs = 16'h0042;
		gv[0] = 24'h008000;
		gv[1] = 24'h7fffff;
		gv[2] = 24'h800000;
		gv[3] = 24'h004000;
		repeat (6) @(posedge ref_clk);
		nrst <= 1'b1;
		note({35{1'b1}}, 35'h0);
		wr(`PRM_ADDR_ROUTE, 32'h0000_0010);
		note(ob(12'hfff, 0, 0, 0, 0), ob(12'h010, 0, 0, 0, 0));
		wr(`PRM_ADDR_ROUTE, 32'h4000_0008);
		note(ob(12'hfff, 0, 0, 0, 0), ob(12'h018, 0, 0, 0, 0));
		wr(`PRM_ADDR_ROUTE, 32'h8000_0010);
		note(ob(12'hfff, 0, 0, 0, 0), ob(12'h008, 0, 0, 0, 0));
		wr(`PRM_ADDR_ROUTE, 32'hc000_0fff);
		wr(9'h0ff, 32'h0000_0000);
		note(ob(12'hfff, 0, 0, 0, 0), ob(12'hff7, 0, 0, 0, 0));
		for (int c = 0; c < 5; c++) begin
			for (int i = 0; i < 2; i++) begin
				wr(`PRM_ADDR_ROUTE, (c == 4) ? 32'h052 : {20'h0, {3{c[2:0]}}, {3{i[0]}}});
				rs = lfsr(rs);
				cpToneSel <= rs[2:0];
				panelIn   <= rs[5:3];
				repeat (4) @(posedge ref_clk);
				src = (c == 1) ? 3'h0 : (c == 2) ? rs[5:3] : rs[2:0];
				src = (c == 4) ? {rs[2], 1'b1, rs[3]} : src ^ {3{i[0]}};
				note(ob(0, 3'h7, 0, 0, 0), ob(0, src, 0, 0, 0));
			end
		end
		wr(`PRM_ADDR_RESET, 32'h1);
		note(ob(0, 0, 1, 0, 0), ob(0, 0, 1, 0, 0));
		repeat (30) @(posedge ref_clk);
		note(ob(0, 0, 1, 0, 0), 35'h0);
		wr(`PRM_ADDR_RESET, 32'h0);
		note(ob(0, 0, 1, 0, 0), 35'h0);
		wr(`PRM_ADDR_SCALE0, 32'h0000_1801);
		wr(`PRM_ADDR_SCALE1, 32'h0003_f001);
		wr(`PRM_ADDR_OFS0, 32'h0000_0100);
		wr(`PRM_ADDR_OFS1, 32'h0003_ff00);
		wr(`PRM_ADDR_POLAR, 32'h0012_34ff);
		adcSample0 <= 16'h1234;
		note(ob(0, 0, 0, 2'h3, 16'hffff), 35'h0);
		sc0 = 18'h01801;
		sc1 = 18'h3f001;
		o0  = 18'h00100;
		o1  = 18'h3ff00;
		for (int f = 0; f < 4; f++) begin
			wr(`PRM_ADDR_GOFS, {8'h0, gv[f]});
			wr(`PRM_ADDR_FMT, 32'h2000_0000 | f);
			go = gv[f];
			fm = f[1:0];
			repeat (3) begin
				rs = lfsr(rs);
				a0 = rs;
				rs = lfsr(rs);
				a1 = rs;
				adcSample0 <= a0;
				adcSample1 <= a1;
				note(ob(0, 0, 0, 2'h3, 16'hffff), ob(0, 0, 0, fm, mexp(a0, a1)));
			end
		end
		repeat (3) @(posedge ref_clk);
		report_and_stop();
	end
endmodule : tb_top
